// >>> pmsi_pkg.sv
// package for port mode select and init block
package pmsi_pkg;
  localparam int          PMSI_REG_W      = 16;
  localparam logic [4:0]  PMSI_REG_CTRL   = 5'h00;
  localparam logic [4:0]  PMSI_REG_ADV    = 5'h04;
  localparam logic [4:0]  PMSI_REG_STAT   = 5'h01;
  // control register fields
  localparam int          PMSI_CTRL_SPEED = 13;
  localparam int          PMSI_CTRL_ANEN  = 12;
  localparam int          PMSI_CTRL_PDN   = 11;
  localparam int          PMSI_CTRL_DUP   = 8;
  // advertisement fields
  localparam int          PMSI_ADV_100FD  = 8;
  localparam int          PMSI_ADV_100HD  = 7;
  localparam int          PMSI_ADV_10FD   = 6;
  localparam int          PMSI_ADV_10HD   = 5;
  localparam logic [4:0]  PMSI_ADV_SEL    = 5'h01;
  // status: bit 0 manual mode, bit 1 in reset, bit 2 low power
  localparam int          PMSI_ST_MANUAL  = 0;
  localparam int          PMSI_ST_RESET   = 1;
  localparam int          PMSI_ST_LOWPWR  = 2;
  typedef enum logic [1:0] {
    PMSI_ST_HOLD = 2'b00,
    PMSI_ST_LOAD = 2'b01,
    PMSI_ST_RUN  = 2'b11,
    PMSI_ST_PDN  = 2'b10
  } pmsi_state_t;
endpackage

// >>> pmsi_regs.sv
// small register store with registered read data
`timescale 1ns/100ps
module pmsi_regs #(
  parameter int W = 16
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_ctrl_def,
  input  wire logic [W-1:0] i_adv_def,
  input  wire logic         i_wr,
  input  wire logic         i_wsel_adv,
  input  wire logic [W-1:0] i_wdata,
  input  wire logic         i_rsel_adv,
  output logic      [W-1:0] o_rdata,
  output logic      [W-1:0] o_ctrl
);
  typedef struct packed {
    logic [W-1:0] ctrl;
    logic [W-1:0] adv;
    logic [W-1:0] rdata;
  } pmsi_mem_t;
  pmsi_mem_t s, next_s;
  always_comb begin
    next_s = s;
    if (i_load) begin
      next_s.ctrl = i_ctrl_def;
      next_s.adv  = i_adv_def;
    end else if (i_wr) begin
      if (i_wsel_adv) next_s.adv = i_wdata;
      else next_s.ctrl = i_wdata;
    end
    next_s.rdata = i_rsel_adv ? s.adv : s.ctrl;
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) s <= '0;
    else s <= next_s;
  end
  assign o_rdata = s.rdata;
  assign o_ctrl  = s.ctrl;
endmodule

// >>> pmsi_port_init.sv
// per-port mode select, strap latch and register guard
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/100ps
module pmsi_port_init (
  input  wire logic                    i_mclk,
  input  wire logic                    i_rst,
  input  wire logic                    i_reset_pin_n,
  input  wire logic                    i_low_power_request,
  input  wire logic                    i_mgmt_disable_select,
  input  wire logic                    i_fiber_media_select,
  input  wire logic                    i_autoneg_strap,
  input  wire logic                    i_speed_strap,
  input  wire logic                    i_duplex_strap,
  input  wire logic [4:0]              i_addr,
  input  wire logic [pmsi_pkg::PMSI_REG_W-1:0] i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic [pmsi_pkg::PMSI_REG_W-1:0] o_rdata,
  output logic                         o_manual_mode,
  output logic                         o_port_reset,
  output logic                         o_low_power,
  output logic [pmsi_pkg::PMSI_REG_W-1:0] o_ctrl
);
  import pmsi_pkg::*;
  localparam int PW = 7;
  typedef struct packed {
    logic [PW-1:0] s1;
    logic [PW-1:0] s2;
    logic [3:0]    strap;
    logic          manual;
    pmsi_state_t   st;
    logic          rd_q;
    logic          rd_stat;
    logic          rd_reg;
    logic [PMSI_REG_W-1:0] stat_q;
  } pmsi_port_t;
  pmsi_port_t s, next_s;
  logic [PMSI_REG_W-1:0] ctrl_def, adv_def, reg_rdata;
  logic rst_pin, pdn_pin, mdis_pin, load, wr_ok, in_reset;

  function automatic logic is_reg(input logic [4:0] a);
    return (a == PMSI_REG_CTRL) || (a == PMSI_REG_ADV);
  endfunction

  assign rst_pin  = s.s2[0];
  assign pdn_pin  = s.s2[1];
  assign mdis_pin = s.s2[2];
  assign in_reset = (s.st == PMSI_ST_HOLD) || (s.st == PMSI_ST_PDN);

  // defaults from latched straps: fiber, autoneg, speed, duplex
  always_comb begin
    ctrl_def = '0;
    adv_def  = '0;
    adv_def[4:0] = PMSI_ADV_SEL;
    ctrl_def[PMSI_CTRL_DUP] = s.strap[0];
    if (s.strap[3]) begin
      ctrl_def[PMSI_CTRL_ANEN]  = s.strap[2];
      ctrl_def[PMSI_CTRL_SPEED] = s.strap[1];
      if (s.strap[2]) begin
        // all high advertises everything; otherwise speed/duplex trim
        adv_def[PMSI_ADV_100FD] = s.strap[1];
        adv_def[PMSI_ADV_100HD] = s.strap[1] | ~s.strap[0];
        adv_def[PMSI_ADV_10FD]  = s.strap[0];
        adv_def[PMSI_ADV_10HD]  = ~(s.strap[1] & ~s.strap[0]);
      end
    end else begin
      ctrl_def[PMSI_CTRL_SPEED] = 1'b1; // fiber runs 100 only
    end
  end

  assign load  = (s.st == PMSI_ST_LOAD);
  // writes dropped silently in manual mode or while held in reset
  assign wr_ok = i_wr & is_reg(i_addr) & ~s.manual & (s.st == PMSI_ST_RUN);

  pmsi_regs #(
    .W (PMSI_REG_W)
  ) u_regs (
    .i_mclk     (i_mclk),
    .i_rst      (i_rst),
    .i_load     (load),
    .i_ctrl_def (ctrl_def),
    .i_adv_def  (adv_def),
    .i_wr       (wr_ok),
    .i_wsel_adv (i_addr == PMSI_REG_ADV),
    .i_wdata    (i_wdata),
    .i_rsel_adv (i_addr == PMSI_REG_ADV),
    .o_rdata    (reg_rdata),
    .o_ctrl     (o_ctrl)
  );

  always_comb begin
    next_s = s;
    // pins pass two flops before use
    next_s.s1 = {i_speed_strap, i_duplex_strap, i_fiber_media_select, i_autoneg_strap,
                 i_mgmt_disable_select, i_low_power_request, i_reset_pin_n};
    next_s.s2 = s.s1;
    next_s.rd_q = i_rd;
    next_s.rd_stat = i_addr == PMSI_REG_STAT;
    next_s.rd_reg  = is_reg(i_addr);
    next_s.stat_q = '0;
    next_s.stat_q[PMSI_ST_MANUAL] = s.manual;
    next_s.stat_q[PMSI_ST_RESET]  = in_reset;
    next_s.stat_q[PMSI_ST_LOWPWR] = (s.st == PMSI_ST_PDN);
    if (pdn_pin) begin
      next_s.st = PMSI_ST_PDN;
    end else if (!rst_pin) begin
      next_s.st = PMSI_ST_HOLD;
      // straps tracked all through reset, last value kept at release
      // strap order: fiber, autoneg, speed, duplex
      next_s.strap = {s.s2[4], s.s2[3], s.s2[6], s.s2[5]};
    end else begin
      case (s.st)
        PMSI_ST_HOLD: begin
          next_s.st = PMSI_ST_LOAD;
          next_s.manual = mdis_pin;
        end
        PMSI_ST_PDN: begin
          // leaving power-down also reloads, as a reset would
          next_s.st = PMSI_ST_LOAD;
          next_s.manual = mdis_pin;
          next_s.strap = {s.s2[4], s.s2[3], s.s2[6], s.s2[5]};
        end
        PMSI_ST_LOAD: next_s.st = PMSI_ST_RUN;
        PMSI_ST_RUN:  next_s.st = PMSI_ST_RUN;
        default:      next_s.st = PMSI_ST_HOLD;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  always_comb begin
    o_rdata = '0;
    // unmapped addresses read zero rather than aliasing the control word
    if (s.rd_q && s.rd_stat) o_rdata = s.stat_q;
    else if (s.rd_q && s.rd_reg) o_rdata = reg_rdata;
  end
  assign o_manual_mode = s.manual;
  assign o_port_reset  = in_reset;
  assign o_low_power   = (s.st == PMSI_ST_PDN);

  a_pdn_forces_lp: assert property (@(posedge i_mclk) disable iff (i_rst)
    pdn_pin |=> o_low_power && o_port_reset)
    else $error("power-down pin did not force low power");
  a_rst_holds: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!rst_pin && !pdn_pin) |=> (s.st == PMSI_ST_HOLD))
    else $error("reset pin low did not hold reset");
  a_mode_high: assert property (@(posedge i_mclk) disable iff (i_rst)
    (s.st == PMSI_ST_HOLD && rst_pin && !pdn_pin && mdis_pin) |=> o_manual_mode)
    else $error("manual mode not entered");
  a_mode_low: assert property (@(posedge i_mclk) disable iff (i_rst)
    (s.st == PMSI_ST_HOLD && rst_pin && !pdn_pin && !mdis_pin) |=> !o_manual_mode)
    else $error("management mode not entered");
  a_manual_no_wr: assert property (@(posedge i_mclk) disable iff (i_rst)
    (s.manual && s.st == PMSI_ST_RUN && !pdn_pin && rst_pin) |=> $stable(o_ctrl))
    else $error("manual mode register changed by write");
  a_wr_takes: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_ok && i_addr == PMSI_REG_CTRL |=> o_ctrl == $past(i_wdata))
    else $error("management write not applied");
  a_load_defaults: assert property (@(posedge i_mclk) disable iff (i_rst)
    load |=> o_ctrl == $past(ctrl_def))
    else $error("defaults not loaded from straps");
  a_all_high_adv: assert property (@(posedge i_mclk) disable iff (i_rst)
    (s.strap == 4'hf) |-> ctrl_def[PMSI_CTRL_ANEN] && adv_def[8:5] == 4'hf)
    else $error("all-high straps wrong defaults");
  a_load_once: assert property (@(posedge i_mclk) disable iff (i_rst)
    load |=> !load)
    else $error("load lasted more than one cycle");
endmodule

// >>> pmsi_mgmt_model.sv
// station management controller and board strap pin model
`timescale 1ns/100ps
module pmsi_mgmt_model (
  input  wire logic        i_mclk,
  input  wire logic [15:0] i_rdata,
  output logic             o_reset_pin_n,
  output logic             o_low_power_request,
  output logic             o_mgmt_disable_select,
  output logic [3:0]       o_straps,
  output logic [4:0]       o_addr,
  output logic [15:0]      o_wdata,
  output logic             o_wr,
  output logic             o_rd
);
  initial begin
    {o_reset_pin_n, o_low_power_request, o_mgmt_disable_select} = 3'b100;
    {o_straps, o_addr, o_wdata, o_wr, o_rd} = '0;
  end
  // straps stay put after reset, as board pins do
  task automatic boot(input logic [3:0] st, input logic md);
    @(posedge i_mclk);
    o_reset_pin_n <= 1'b0;
    o_straps <= st;
    o_mgmt_disable_select <= md;
    repeat (4) @(posedge i_mclk);
    o_reset_pin_n <= 1'b1;
  endtask
  task automatic pwr(input logic v);
    @(posedge i_mclk);
    o_low_power_request <= v;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    {o_wr, o_addr, o_wdata} <= {1'b1, a, d};
    @(posedge i_mclk);
    o_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe edge
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge i_mclk);
    {o_rd, o_addr} <= {1'b1, a};
    @(posedge i_mclk);
    o_rd <= 1'b0;
    #1 d = i_rdata;
  endtask
endmodule

// >>> tb.sv
// self-checking bench for the port mode select block
`timescale 1ns/100ps
module tb;
  import pmsi_pkg::*;
  logic        i_mclk, i_rst, pin_n, lpr, mds, wr, rd;
  logic [3:0]  st;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata, ctrl, d, prev, w;
  logic        manual, preset, lowp;
  logic [31:0] seed = 32'h565e4b2d;
  logic [31:0] r;
  logic [2:0]  cfg;
  int          err_total = 0;
  int          num_checks = 0;
  pmsi_mgmt_model mgmt (.i_mclk(i_mclk), .i_rdata(rdata), .o_reset_pin_n(pin_n),
    .o_low_power_request(lpr), .o_mgmt_disable_select(mds), .o_straps(st),
    .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  pmsi_port_init dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_reset_pin_n(pin_n),
    .i_low_power_request(lpr), .i_mgmt_disable_select(mds),
    .i_fiber_media_select(st[3]), .i_autoneg_strap(st[2]), .i_speed_strap(st[1]),
    .i_duplex_strap(st[0]), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_manual_mode(manual), .o_port_reset(preset),
    .o_low_power(lowp), .o_ctrl(ctrl));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // {speed, autoneg, duplex}; fiber forces 100 with autoneg off
  function automatic logic [2:0] exp_cfg(input logic [3:0] s);
    return s[3] ? {s[1], s[2], s[0]} : {1'b1, 1'b0, s[0]};
  endfunction
  function automatic logic [15:0] exp_adv(input logic [3:0] s);
    if (!s[3]) return 16'h0001;
    return {7'h00, s[1], s[1] | !s[0], s[0], !s[1] | s[0], 5'h01};
  endfunction
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask
  task automatic wait_st(input logic pr, input logic lp);
    int n;
    n = 0;
    while ((preset !== pr || lowp !== lp) && n < 30) begin
      // sample mid-cycle, away from the edge that launches the outputs
      @(negedge i_mclk);
      n++;
    end
    chk("reset_lowpower", {14'h0, pr, lp}, {14'h0, preset, lowp});
    if (n == 30) test_done();
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  initial begin
    i_rst = 1'b1;
    repeat (4) @(posedge i_mclk);
    i_rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      r = rnd();
      mgmt.boot((i == 0) ? 4'hf : (i == 1) ? 4'h6 : (i == 2) ? 4'hc : (i == 3) ? 4'he :
                r[3:0], (i < 2) ? i[0] : r[4]);
      wait_st(1'b0, 1'b0);
      // defaults land one cycle after reset drops
      @(negedge i_mclk);
      cfg = exp_cfg(st);
      if (cfg[1]) chk("autoneg", 16'h1, {15'h0, ctrl[12]});
      else chk("ctrl", {13'h0, cfg}, {13'h0, ctrl[13], ctrl[12], ctrl[8]});
      mgmt.rd(PMSI_REG_ADV, d);
      if (!st[3] || st[2]) chk("adv", exp_adv(st), d);
      mgmt.rd(PMSI_REG_STAT, d);
      chk("status", {15'h0, mds}, {15'h0, d[PMSI_ST_MANUAL]});
      chk("manual", {15'h0, mds}, {15'h0, manual});
      prev = ctrl;
      w = r[31:16] & 16'h77ff;
      mgmt.wr(PMSI_REG_CTRL, w);
      mgmt.rd(PMSI_REG_CTRL, d);
      chk("ctrl_wr", mds ? prev : w, d);
      chk("ctrl_out", mds ? prev : w, ctrl);
    end
    mgmt.rd(5'h1f, d);
    chk("unmapped", 16'h0, d);
    mgmt.pwr(1'b1);
    wait_st(1'b1, 1'b1);
    mgmt.pwr(1'b0);
    wait_st(1'b0, 1'b0);
    @(negedge i_mclk);
    chk("ctrl_reload", {13'h0, cfg}, {13'h0, ctrl[13], ctrl[12], ctrl[8]});
    test_done();
  end
endmodule
